//--- verilog/serirq_ddma_shadow_config.sv
/*
 * APB register bank for the serial interrupt line setup, the distributed
 * DMA channel placement and the DMA shadow read-back index.
 * Assumes an APB master on pclk and a DMA core that presents its slave
 * channel base registers on the same clock; no synchronisers are needed.
 */
`timescale 1ns/1ps
`default_nettype none
module serirq_ddma_shadow_config
   import bridge_cfg_pkg::*;
(
   // Clock and reset.
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave.
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [addr_width-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // DMA core base registers, slave channels 0 to 3.
   input  wire logic [3:0][15:0]      base_address,
   input  wire logic [3:0][15:0]      base_word_count,
   // Configuration towards the serial interrupt engine and DMA router.
   output logic                       serial_irq_enable,
   output logic      [1:0]            stop_frame_clocks,
   output logic      [3:0]            start_frame_clocks,
   output logic      [7:0]            dma_channel_on_pci
);

   logic [7:0] serial_interrupt_control;
   logic [7:0] dma_channel_side_select;
   logic [4:0] shadow_index;
   logic [7:0] shadow_byte;
   logic       access;
   logic       wr_done;
   logic       mapped;
   logic [7:0] next_rdata;

   // ==========================================================
   // Bus phases. The answer comes one cycle into the access phase so that
   // read data can leave from a flip-flop.
   assign access  = psel & penable;
   assign wr_done = access & pready & pwrite & pstrb[0];

   always_comb begin
      mapped     = 1'b1;
      next_rdata = 8'h00;
      case (paddr)
         shadow_select_data_addr:       next_rdata = shadow_select_data_value;
         serial_interrupt_control_addr: next_rdata = serial_interrupt_control;
         dma_channel_side_select_addr:  next_rdata = dma_channel_side_select;
         shadow_index_addr:             next_rdata = {3'h0, shadow_index};
         shadow_readback_addr:          next_rdata = shadow_byte;
         default:                       mapped = 1'b0;
      endcase
   end

   // Handshake and read data; prdata is cleared between transfers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (access && !pready) begin
         pready  <= 1'b1;
         pslverr <= ~mapped;
         prdata  <= (mapped && !pwrite) ? {24'h00_0000, next_rdata} : 32'h0000_0000;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end

   // ==========================================================
   // Serial interrupt control. Reserved bits never store, and the reserved
   // start code is dropped so the engine never sees an undefined width.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_interrupt_control <= serial_interrupt_control_rst;
      end else if (wr_done && paddr == serial_interrupt_control_addr) begin
         serial_interrupt_control[sic_enable_bit] <= pwdata[sic_enable_bit];
         serial_interrupt_control[sic_stop_bit]   <= pwdata[sic_stop_bit];
         serial_interrupt_control[5:2]            <= 4'h0;
         if (pwdata[1:0] != start_code_rsvd) begin
            serial_interrupt_control[1:0] <= pwdata[1:0];
         end
      end
   end

   // Distributed DMA channel placement; a set bit means the PCI side.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_channel_side_select <= dma_channel_side_select_rst;
      end else if (wr_done && paddr == dma_channel_side_select_addr) begin
         dma_channel_side_select <= pwdata[7:0];
      end
   end

   // Shadow index.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shadow_index <= shadow_index_rst;
      end else if (wr_done && paddr == shadow_index_addr) begin
         shadow_index <= pwdata[4:0];
      end
   end

   shadow_byte_select shadow_byte_select_inst (
      .code            (shadow_index),
      .base_address    (base_address),
      .base_word_count (base_word_count),
      .byte_out        (shadow_byte)
   );

   // ==========================================================
   // Decoded outputs, one cycle behind the register so each is a flip-flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_irq_enable  <= 1'b0;
         stop_frame_clocks  <= stop_clocks_2;
         start_frame_clocks <= start_clocks_6;
         dma_channel_on_pci <= 8'h00;
      end else begin
         serial_irq_enable  <= serial_interrupt_control[sic_enable_bit];
         stop_frame_clocks  <= serial_interrupt_control[sic_stop_bit] ? stop_clocks_3 : stop_clocks_2;
         case (serial_interrupt_control[1:0])
            start_code_4: start_frame_clocks <= start_clocks_4;
            start_code_8: start_frame_clocks <= start_clocks_8;
            default:      start_frame_clocks <= start_clocks_6;
         endcase
         dma_channel_on_pci <= dma_channel_side_select;
      end
   end

   // ==========================================================
   // Checks on the bank.
   sequence read_of_6f;
      access && !pready && !pwrite && paddr == shadow_select_data_addr;
   endsequence

   sequence write_of_70;
      wr_done && paddr == serial_interrupt_control_addr;
   endsequence

   sequence read_of_70;
      access && !pready && !pwrite && paddr == serial_interrupt_control_addr;
   endsequence

   property shadow_zero_p;
      @(posedge pclk) disable iff (!presetn)
      read_of_6f |=> pready && !pslverr && prdata == 32'h0000_0000;
   endproperty

   shadow_zero_a: assert property (shadow_zero_p) else $error("index 6f did not read zero");

   control_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      write_of_70 |=> serial_interrupt_control[7:6] == $past(pwdata[7:6]))
      else $error("control write lost");

   irq_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
      write_of_70 |-> ##2 serial_irq_enable == $past(pwdata[7], 2))
      else $error("serial enable output wrong");

   stop_width_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 stop_frame_clocks == ($past(serial_interrupt_control[6]) ? 2'h3 : 2'h2))
      else $error("stop width wrong");

   start_width_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(serial_interrupt_control[1:0]) == 2'h2 |-> start_frame_clocks == 4'h8)
      else $error("start width wrong");

   start_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
      write_of_70 and (pwdata[1:0] == 2'h3) |=> $stable(serial_interrupt_control[1:0]))
      else $error("reserved start code stored");

   side_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_done && paddr == dma_channel_side_select_addr |-> ##2 dma_channel_on_pci == $past(pwdata[7:0], 2))
      else $error("channel side not applied");

   ch2_side_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 dma_channel_on_pci[2] == $past(dma_channel_side_select[2]))
      else $error("channel 2 placement wrong");

   shadow_ch2_a: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pready && !pwrite && paddr == shadow_readback_addr && shadow_index == 5'h0e
      |=> prdata[7:0] == $past(base_address[2][7:0]))
      else $error("shadow channel 2 low byte wrong");

   reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      serial_interrupt_control[5:2] == 4'h0)
      else $error("reserved control bits set");

   // Handshake shape: exactly one wait state and a one-cycle answer, so a
   // master that waits for pready never sees a stale pulse.
   one_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pready |=> pready)
      else $error("answer not one cycle after access");

   ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready held longer than one cycle");

   side_store_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_done && paddr == dma_channel_side_select_addr |=> dma_channel_side_select == $past(pwdata[7:0]))
      else $error("channel side write lost");

   // Each legal start code maps to its own width one cycle later.
   start_four_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(serial_interrupt_control[1:0]) == 2'h0 |-> start_frame_clocks == 4'h4)
      else $error("start width four wrong");

   start_six_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(serial_interrupt_control[1:0]) == 2'h1 |-> start_frame_clocks == 4'h6)
      else $error("start width six wrong");

   reserved_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_70 |=> prdata[5:2] == 4'h0)
      else $error("reserved control bits read back set");

endmodule
`default_nettype wire

//--- verilog/bridge_cfg_pkg.sv
/*
 * Constants shared by the bridge configuration register bank: register
 * indices and byte addresses, field positions, reset values and the pulse
 * width figures of the serial interrupt line.
 * Assumes a 32-bit APB with byte addresses and one register per word.
 */
package bridge_cfg_pkg;

   // ==========================================================
   // Register indices; the byte address is four times the index.
   localparam logic [7:0]  shadow_select_data_idx       = 8'h6f;
   localparam logic [7:0]  serial_interrupt_control_idx = 8'h70;
   localparam logic [7:0]  dma_channel_side_select_idx  = 8'h71;
   localparam logic [7:0]  shadow_index_idx             = 8'h72;
   localparam logic [7:0]  shadow_readback_idx          = 8'h73;
   localparam int          addr_width                   = 12;
   localparam logic [11:0] shadow_select_data_addr       = {2'h0, shadow_select_data_idx, 2'h0};
   localparam logic [11:0] serial_interrupt_control_addr = {2'h0, serial_interrupt_control_idx, 2'h0};
   localparam logic [11:0] dma_channel_side_select_addr  = {2'h0, dma_channel_side_select_idx, 2'h0};
   localparam logic [11:0] shadow_index_addr             = {2'h0, shadow_index_idx, 2'h0};
   localparam logic [11:0] shadow_readback_addr          = {2'h0, shadow_readback_idx, 2'h0};

   // ==========================================================
   // Field positions of the serial interrupt control and DMA channel side select registers.
   localparam int          sic_enable_bit   = 7;
   localparam int          sic_stop_bit     = 6;
   localparam int          sic_start_lsb    = 0;
   localparam int          dma_ch2_side_bit = 2;

   // ==========================================================
   // Reset values.
   localparam logic [7:0]  shadow_select_data_value      = 8'h00;
   localparam logic [7:0]  serial_interrupt_control_rst  = 8'h01;
   localparam logic [7:0]  dma_channel_side_select_rst   = 8'h00;
   localparam logic [4:0]  shadow_index_rst              = 5'h00;

   // ==========================================================
   // Start-frame codes and pulse widths in bus clock periods.
   localparam logic [1:0]  start_code_4     = 2'h0;
   localparam logic [1:0]  start_code_6     = 2'h1;
   localparam logic [1:0]  start_code_8     = 2'h2;
   localparam logic [1:0]  start_code_rsvd  = 2'h3;
   localparam logic [3:0]  start_clocks_4   = 4'h4;
   localparam logic [3:0]  start_clocks_6   = 4'h6;
   localparam logic [3:0]  start_clocks_8   = 4'h8;
   localparam logic [1:0]  stop_clocks_2    = 2'h2;
   localparam logic [1:0]  stop_clocks_3    = 2'h3;

   // ==========================================================
   // Shadow read-back codes, first code of the groups of channels 0, 1 and 3, each code of channel 2.
   localparam logic [4:0]  shadow_ch0_first = 5'h05;
   localparam logic [4:0]  shadow_ch1_first = 5'h09;
   localparam logic [4:0]  shadow_ch2_bah   = 5'h0d;
   localparam logic [4:0]  shadow_ch2_bal   = 5'h0e;
   localparam logic [4:0]  shadow_ch2_wcl   = 5'h0f;
   localparam logic [4:0]  shadow_ch2_wch   = 5'h10;
   localparam logic [4:0]  shadow_ch3_first = 5'h11;

endpackage

//--- verilog/shadow_byte_select.sv
/*
 * Picks one byte of a slave DMA channel's base address or base word count
 * from a five-bit shadow index. Purely combinational.
 * Assumes the DMA core presents its base registers on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module shadow_byte_select
   import bridge_cfg_pkg::*;
(
   // Selection.
   input  wire logic [4:0]        code,
   // Channel base registers.
   input  wire logic [3:0][15:0]  base_address,
   input  wire logic [3:0][15:0]  base_word_count,
   // Chosen byte.
   output logic      [7:0]        byte_out
);

   // ==========================================================
   // Byte decode. Channel 2 swaps its address bytes, so it is listed apart.
   always_comb begin
      byte_out = 8'h00;
      case (code)
         shadow_ch0_first:          byte_out = base_address[0][7:0];
         shadow_ch0_first + 5'h1:   byte_out = base_address[0][15:8];
         shadow_ch0_first + 5'h2:   byte_out = base_word_count[0][7:0];
         shadow_ch0_first + 5'h3:   byte_out = base_word_count[0][15:8];
         shadow_ch1_first:          byte_out = base_address[1][7:0];
         shadow_ch1_first + 5'h1:   byte_out = base_address[1][15:8];
         shadow_ch1_first + 5'h2:   byte_out = base_word_count[1][7:0];
         shadow_ch1_first + 5'h3:   byte_out = base_word_count[1][15:8];
         shadow_ch2_bal:            byte_out = base_address[2][7:0];
         shadow_ch2_bah:            byte_out = base_address[2][15:8];
         shadow_ch2_wcl:            byte_out = base_word_count[2][7:0];
         shadow_ch2_wch:            byte_out = base_word_count[2][15:8];
         shadow_ch3_first:          byte_out = base_address[3][7:0];
         shadow_ch3_first + 5'h1:   byte_out = base_address[3][15:8];
         shadow_ch3_first + 5'h2:   byte_out = base_word_count[3][7:0];
         shadow_ch3_first + 5'h3:   byte_out = base_word_count[3][15:8];
         default:                   byte_out = 8'h00;
      endcase
   end

endmodule
`default_nettype wire

//--- verification/dma_base_model.sv
/*
 * Behavioural model of the DMA core: slave channel base registers.
 * Assumes the bench changes salt only between shadow reads.
 */
`timescale 1ns/1ps
`default_nettype none
module dma_base_model (
   // Clock and pattern seed.
   input  wire logic             pclk,
   input  wire logic [7:0]       salt,
   // Base registers, slave channels 0 to 3.
   output logic      [3:0][15:0] base_address,
   output logic      [3:0][15:0] base_word_count
);
   // ==========================================================
   // Every byte differs, so a wrong byte pick cannot pass unseen.
   always_ff @(posedge pclk) begin
      for (int i = 0; i < 4; i++) begin
         base_address[i]    <= {salt ^ 8'(4*i+1), salt ^ 8'(4*i)};
         base_word_count[i] <= {salt ^ 8'(4*i+3), salt ^ 8'(4*i+2)};
      end
   end
endmodule
`default_nettype wire

//--- verification/serirq_ddma_shadow_config_tb_top.sv
/*
 * Self-checking bench for the serial interrupt and DMA placement bank.
 * Assumes the design answers APB with a registered pready pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module serirq_ddma_shadow_config_tb_top;
   import bridge_cfg_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, start_frame_clocks;
   logic [3:0][15:0] base_address, base_word_count;
   logic serial_irq_enable;
   logic [1:0] stop_frame_clocks;
   logic [7:0] dma_channel_on_pci, salt;
   int n_errors = 0;
   int num_checks = 0;
   logic [7:0] wv[5] = '{8'hff, 8'h00, 8'h41, 8'h82, 8'h03};
   logic [7:0] rv[5] = '{8'hc1, 8'h00, 8'h41, 8'h82, 8'h02};
   logic [3:0] sv[5] = '{4'h6, 4'h4, 4'h6, 4'h8, 4'h8};

   // ==========================================================
   // Design and DMA core model.
   serirq_ddma_shadow_config serirq_ddma_shadow_config_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .base_address(base_address), .base_word_count(base_word_count),
      .serial_irq_enable(serial_irq_enable), .stop_frame_clocks(stop_frame_clocks),
      .start_frame_clocks(start_frame_clocks), .dma_channel_on_pci(dma_channel_on_pci));
   dma_base_model dma_base_model_inst (.pclk(pclk), .salt(salt),
      .base_address(base_address), .base_word_count(base_word_count));

   // Clock of 4 ns period.
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // ==========================================================
   // Compare, bus and verdict tasks.
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, x, g);
      end
   endtask

   // One transfer, entered just after a rising edge; one idle edge follows.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      if (n >= 20) begin
         chk("pready", 1, 0);
         conclude();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk("prdata", x, r);
      chk("pslverr", 32'(xe), 32'(e));
   endtask

   // Expected shadow byte; channel 2 lists its address bytes high first.
   function automatic logic [7:0] shadow_exp(input logic [4:0] c);
      int ch, k;
      logic [15:0] v;
      if (c < 5'h05 || c > 5'h14) return 8'h00;
      ch = (32'(c) - 5) / 4;
      k = (32'(c) - 5) % 4;
      v = (k < 2) ? base_address[ch] : base_word_count[ch];
      if (ch == 2 && k < 2) k = 1 - k;
      return (k % 2 == 1) ? v[15:8] : v[7:0];
   endfunction

   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog well above the expected run of about 2 us.
   initial begin
      #40000;
      n_errors++;
      conclude();
   end

   // ==========================================================
   // Test sequence.
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'h1;
      salt = 8'h5a;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("enable", 0, 32'(serial_irq_enable));
      chk("start", 6, 32'(start_frame_clocks));
      rd(serial_interrupt_control_addr, 32'h01, 1'b0);
      rd(dma_channel_side_select_addr, 32'h00, 1'b0);
      wr(shadow_select_data_addr, 32'hff);
      rd(shadow_select_data_addr, 32'h00, 1'b0);
      // Control writes: reserved bits and the reserved start code are dropped.
      for (int i = 0; i < 5; i++) begin
         wr(serial_interrupt_control_addr, 32'(wv[i]));
         rd(serial_interrupt_control_addr, 32'(rv[i]), 1'b0);
         repeat (2) @(posedge pclk);
         chk("enable", 32'(rv[i][7]), 32'(serial_irq_enable));
         chk("stop", rv[i][6] ? 3 : 2, 32'(stop_frame_clocks));
         chk("start", 32'(sv[i]), 32'(start_frame_clocks));
      end
      // A reset in mid-run must bring the start width back from eight to six.
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("start", 6, 32'(start_frame_clocks));
      rd(serial_interrupt_control_addr, 32'h01, 1'b0);
      // Channel placement, bit 2 alone and then every other bit.
      for (int i = 0; i < 2; i++) begin
         wr(dma_channel_side_select_addr, i ? 32'hfb : 32'h04);
         rd(dma_channel_side_select_addr, i ? 32'hfb : 32'h04, 1'b0);
         repeat (2) @(posedge pclk);
         chk("on_pci", i ? 32'hfb : 32'h04, 32'(dma_channel_on_pci));
      end
      rd(12'h000, 32'h0, 1'b1);
      // Every shadow code, with new base values for the upper half.
      for (int c = 0; c < 32; c++) begin
         if (c == 16) salt <= 8'ha5;
         wr(shadow_index_addr, 32'(c));
         rd(shadow_index_addr, 32'(c), 1'b0);
         rd(shadow_readback_addr, 32'(shadow_exp(5'(c))), 1'b0);
      end
      conclude();
   end
endmodule
`default_nettype wire
